// ### logic/asf_datapath.sv
// Add/subtract datapath with condition flags, controlled over APB
//
// Our own choices: the placing of the registers and the APB slave port.

// Contract
// - Carry sum adds both sources plus one when carry is set, writes the result, sets all flags.
// - The plain sum adds the first source to a register or constant and leaves flags alone.
// - The flag-setting sum gives the plain sum result and updates N, Z, C and V.
// - Negate writes zero minus the first source and sets all flags; its only constant is 0.
// - Borrow difference subtracts the second source, one more when carry is set, sets all flags.
// - The plain difference subtracts a register or constant and leaves the flags alone.
// - The flag-setting difference gives the plain difference result and updates all four flags.
// - With no result register given, the first source register is the destination.
// - Carry sum, negate and borrow difference exist only in flag-setting form.
module asf_datapath (
   input wire logic clk, // Core clock, 25 MHz
   input wire logic reset_n, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction, high for write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready, low while an operation runs
   output logic pslverr // APB error on unmapped address
);

   // ----------------------------------------------------------------
   // Types and state
   // ----------------------------------------------------------------
   typedef struct packed {
      asf_pkg::asf_state_e state;
      logic [2:0] op;
      logic set_flags;
      logic use_imm;
      logic [3:0] rd;
      logic [3:0] first_source_register;
      logic [3:0] second_operand_register;
      logic [31:0] imm;
      logic [3:0] flags;
      logic [31:0] result;
      logic [3:0] rf_sel;
   } asf_core_s;

   asf_core_s st_r;
   asf_core_s st_nxt;

   logic [31:0] src_a;
   logic [31:0] src_b;
   logic [3:0] addr_a;
   logic rf_wr_en;
   logic [3:0] rf_wr_addr;
   logic [31:0] rf_wr_data;
   logic xfer;
   logic [35:0] alu_out;
   logic [31:0] alu_a;
   logic [31:0] alu_b;
   logic alu_cin;
   logic alu_valid;
   logic alu_flag_upd;

   // ----------------------------------------------------------------
   // Adder with flag derivation: returns {N, Z, C, V, sum}
   // ----------------------------------------------------------------
   function automatic logic [35:0] asf_add(input logic [31:0] a, input logic [31:0] b,
                                           input logic cin);
      logic [32:0] wide;
      logic ovf;
      wide = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
      ovf = (a[31] == b[31]) && (wide[31] != a[31]);
      return {wide[31], (wide[31:0] == 32'h0000_0000), wide[32], ovf, wide[31:0]};
   endfunction

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Port A follows the selected index when idle so software can read it
   assign addr_a = (st_r.state == asf_pkg::ST_IDLE) ? st_r.rf_sel : st_r.first_source_register;

   asf_regfile u_regfile (
      .clk(clk),
      .reset_n(reset_n),
      .rd_addr_a(addr_a),
      .rd_addr_b(st_r.second_operand_register),
      .wr_en(rf_wr_en),
      .wr_addr(rf_wr_addr),
      .wr_data(rf_wr_data),
      .rd_data_a(src_a),
      .rd_data_b(src_b)
   );

   // ----------------------------------------------------------------
   // Operand steering for the adder
   // ----------------------------------------------------------------
   always_comb begin
      alu_a = src_a;
      alu_b = st_r.use_imm ? st_r.imm : src_b;
      alu_cin = 1'b0;
      alu_valid = 1'b1;
      alu_flag_upd = st_r.set_flags;
      unique case (st_r.op)
         asf_pkg::OP_SUM: begin
            alu_cin = 1'b0;
         end
         asf_pkg::OP_CARRY_SUM: begin
            alu_b = src_b;
            alu_cin = st_r.flags[asf_pkg::FLAG_C];
            alu_flag_upd = 1'b1;
         end
         asf_pkg::OP_DIFFERENCE: begin
            alu_b = ~(st_r.use_imm ? st_r.imm : src_b);
            alu_cin = 1'b1;
         end
         asf_pkg::OP_BORROW_DIFFERENCE: begin
            alu_b = ~src_b;
            alu_cin = ~st_r.flags[asf_pkg::FLAG_C];
            alu_flag_upd = 1'b1;
         end
         asf_pkg::OP_NEGATE: begin
            alu_a = 32'h0000_0000;
            alu_b = ~src_a;
            alu_cin = 1'b1;
            alu_flag_upd = 1'b1;
         end
         default: begin
            alu_valid = 1'b0;
            alu_flag_upd = 1'b0;
         end
      endcase
   end

   assign alu_out = asf_add(alu_a, alu_b, alu_cin);

   // ----------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------
   // Every access stalls until the sequencer is idle
   assign pready = (st_r.state == asf_pkg::ST_IDLE);
   assign xfer = psel && penable && pready;

   // Unmapped address answers with an error
   always_comb begin
      unique case (paddr)
         asf_pkg::ADDR_CTRL, asf_pkg::ADDR_IMM, asf_pkg::ADDR_FLAGS, asf_pkg::ADDR_RESULT,
         asf_pkg::ADDR_RF_SEL, asf_pkg::ADDR_RF_DATA, asf_pkg::ADDR_STATUS: begin
            pslverr = 1'b0;
         end
         default: begin
            pslverr = psel && penable;
         end
      endcase
   end

   // Read data mux
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         asf_pkg::ADDR_CTRL: begin
            prdata[asf_pkg::CTRL_OP_LSB +: 3] = st_r.op;
            prdata[asf_pkg::CTRL_SET_FLAGS] = st_r.set_flags;
            prdata[asf_pkg::CTRL_USE_IMM] = st_r.use_imm;
            prdata[asf_pkg::CTRL_RD_LSB +: 4] = st_r.rd;
            prdata[asf_pkg::CTRL_FIRST_LSB +: 4] = st_r.first_source_register;
            prdata[asf_pkg::CTRL_SECOND_LSB +: 4] = st_r.second_operand_register;
         end
         asf_pkg::ADDR_IMM: prdata = st_r.imm;
         asf_pkg::ADDR_FLAGS: prdata[3:0] = st_r.flags;
         asf_pkg::ADDR_RESULT: prdata = st_r.result;
         asf_pkg::ADDR_RF_SEL: prdata[3:0] = st_r.rf_sel;
         asf_pkg::ADDR_RF_DATA: prdata = src_a;
         asf_pkg::ADDR_STATUS: prdata[asf_pkg::STATUS_BUSY] = ~pready;
         default: prdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Register file write: software when idle, result at execute
   // ----------------------------------------------------------------
   always_comb begin
      rf_wr_en = 1'b0;
      rf_wr_addr = st_r.rf_sel;
      rf_wr_data = pwdata;
      if (st_r.state == asf_pkg::ST_EXEC) begin
         rf_wr_en = alu_valid;
         rf_wr_addr = st_r.rd;
         rf_wr_data = alu_out[31:0];
      end else if (xfer && pwrite && (paddr == asf_pkg::ADDR_RF_DATA)) begin
         rf_wr_en = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer and software registers
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      unique case (st_r.state)
         asf_pkg::ST_IDLE: begin
            if (xfer && pwrite) begin
               unique case (paddr)
                  asf_pkg::ADDR_CTRL: begin
                     st_nxt.op = pwdata[asf_pkg::CTRL_OP_LSB +: 3];
                     st_nxt.set_flags = pwdata[asf_pkg::CTRL_SET_FLAGS];
                     st_nxt.use_imm = pwdata[asf_pkg::CTRL_USE_IMM];
                     st_nxt.first_source_register = pwdata[asf_pkg::CTRL_FIRST_LSB +: 4];
                     st_nxt.second_operand_register = pwdata[asf_pkg::CTRL_SECOND_LSB +: 4];
                     // Two-operand form writes back to the first source
                     st_nxt.rd = pwdata[asf_pkg::CTRL_RD_GIVEN] ?
                                 pwdata[asf_pkg::CTRL_RD_LSB +: 4] :
                                 pwdata[asf_pkg::CTRL_FIRST_LSB +: 4];
                     st_nxt.state = asf_pkg::ST_FETCH;
                  end
                  asf_pkg::ADDR_IMM: st_nxt.imm = pwdata;
                  asf_pkg::ADDR_FLAGS: st_nxt.flags = pwdata[3:0];
                  asf_pkg::ADDR_RF_SEL: st_nxt.rf_sel = pwdata[3:0];
                  default: st_nxt.state = asf_pkg::ST_IDLE;
               endcase
            end
         end
         asf_pkg::ST_FETCH: begin
            st_nxt.state = asf_pkg::ST_EXEC;
         end
         asf_pkg::ST_EXEC: begin
            if (alu_valid) begin
               st_nxt.result = alu_out[31:0];
            end
            // Plain forms keep the flags
            if (alu_flag_upd) begin
               st_nxt.flags[asf_pkg::FLAG_N] = alu_out[35];
               st_nxt.flags[asf_pkg::FLAG_Z] = alu_out[34];
               st_nxt.flags[asf_pkg::FLAG_C] = alu_out[33];
               st_nxt.flags[asf_pkg::FLAG_V] = alu_out[32];
            end
            st_nxt.state = asf_pkg::ST_IDLE;
         end
         default: st_nxt.state = asf_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r.state <= asf_pkg::ST_IDLE;
         st_r.op <= 3'h0;
         st_r.set_flags <= 1'b0;
         st_r.use_imm <= 1'b0;
         st_r.rd <= asf_pkg::RST_INDEX;
         st_r.first_source_register <= asf_pkg::RST_INDEX;
         st_r.second_operand_register <= asf_pkg::RST_INDEX;
         st_r.imm <= asf_pkg::RST_WORD;
         st_r.flags <= asf_pkg::RST_FLAGS;
         st_r.result <= asf_pkg::RST_WORD;
         st_r.rf_sel <= asf_pkg::RST_INDEX;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // asf_datapath

// ### inc/asf_pkg.sv
// Package of constants and types for the add/subtract flag datapath
package asf_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets on the APB
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IMM = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0c;
   localparam logic [7:0] ADDR_RF_SEL = 8'h10;
   localparam logic [7:0] ADDR_RF_DATA = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_SET_FLAGS = 3;
   localparam int CTRL_USE_IMM = 4;
   localparam int CTRL_RD_GIVEN = 5;
   localparam int CTRL_RD_LSB = 8;
   localparam int CTRL_FIRST_LSB = 12;
   localparam int CTRL_SECOND_LSB = 16;

   // Flag register bit positions
   localparam int FLAG_V = 0;
   localparam int FLAG_C = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;

   // Status register bit position
   localparam int STATUS_BUSY = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [3:0] RST_FLAGS = 4'h0;
   localparam logic [3:0] RST_INDEX = 4'h0;

   // Register file shape
   localparam int RF_DEPTH = 16;
   localparam int RF_WIDTH = 32;

   // ----------------------------------------------------------------
   // Operation codes and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_SUM = 3'h0,
      OP_CARRY_SUM = 3'h1,
      OP_DIFFERENCE = 3'h2,
      OP_BORROW_DIFFERENCE = 3'h3,
      OP_NEGATE = 3'h4
   } asf_op_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FETCH = 3'b010,
      ST_EXEC = 3'b100
   } asf_state_e;

endpackage

// ### logic/asf_regfile.sv
// Sixteen-word register file with two registered read ports and one write port
module asf_regfile (
   input wire logic clk, // Core clock
   input wire logic reset_n, // Synchronous reset, active low
   input wire logic [3:0] rd_addr_a, // Read port A index
   input wire logic [3:0] rd_addr_b, // Read port B index
   input wire logic wr_en, // Write strobe
   input wire logic [3:0] wr_addr, // Write index
   input wire logic [31:0] wr_data, // Write word
   output logic [31:0] rd_data_a, // Registered read data A
   output logic [31:0] rd_data_b // Registered read data B
);

   typedef struct packed {
      logic [asf_pkg::RF_DEPTH-1:0][asf_pkg::RF_WIDTH-1:0] mem;
      logic [31:0] data_a;
      logic [31:0] data_b;
   } asf_rf_s;

   asf_rf_s st_r;
   asf_rf_s st_nxt;

   // Read reflects a write of the previous edge; write lands in the array
   always_comb begin
      st_nxt = st_r;
      st_nxt.data_a = st_r.mem[rd_addr_a];
      st_nxt.data_b = st_r.mem[rd_addr_b];
      if (wr_en) begin
         st_nxt.mem[wr_addr] = wr_data;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data_a = st_r.data_a;
   assign rd_data_b = st_r.data_b;

endmodule // asf_regfile

// ### test/asf_datapath_monitor.sv
// Checker of the datapath's APB port behaviour
module asf_datapath_monitor (
   input wire logic clk, // Clock
   input wire logic reset_n, // Reset, active low
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [7:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr // Error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Accepted access, operation start and register read
   sequence s_acc;
      psel && penable && pready;
   endsequence
   sequence s_start;
      s_acc ##0 pwrite && paddr == asf_pkg::ADDR_CTRL;
   endsequence
   sequence s_rd(a);
      s_acc ##0 !pwrite && paddr == a;
   endsequence
   property p_op_stall;
      s_start |=> !pready [*2] ##1 pready;
   endproperty
   a_op_stall: assert property (p_op_stall) else $error("op stall length wrong");
   property p_stall_cause;
      $fell(pready) |-> $past(pwrite) && $past(penable) && $past(paddr) == asf_pkg::ADDR_CTRL;
   endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("stall without op start");
   property p_stall_bound;
      !pready |-> ##[1:2] pready;
   endproperty
   a_stall_bound: assert property (p_stall_bound) else $error("stall too long");
   property p_err_phase;
      pslverr |-> psel && penable;
   endproperty
   a_err_phase: assert property (p_err_phase) else $error("error outside access");
   property p_err_map;
      psel && penable && paddr > 8'h18 |-> pslverr;
   endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
   property p_no_err;
      psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr;
   endproperty
   a_no_err: assert property (p_no_err) else $error("mapped access refused");
   property p_flag_bits;
      s_rd(asf_pkg::ADDR_FLAGS) |-> prdata[31:4] == 28'h0;
   endproperty
   a_flag_bits: assert property (p_flag_bits) else $error("flag read wide");
   property p_status;
      s_rd(asf_pkg::ADDR_STATUS) |-> prdata == 32'h0;
   endproperty
   a_status: assert property (p_status) else $error("status not zero");
endmodule // asf_datapath_monitor

bind asf_datapath asf_datapath_monitor asf_datapath_monitor_i (
   .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ### test/asf_decoder_model.sv
// Decoder-side model that issues APB transfers toward the datapath
module asf_decoder_model (
   input wire logic clk, // Core clock
   output logic psel, // Select
   output logic penable, // Enable
   output logic pwrite, // Direction
   output logic [7:0] paddr, // Address
   output logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr // Error
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle from time zero
   initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
   // One transfer, held until ready is seen high at a rising edge; answer taken there
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e, output logic t);
      int n;
      logic r;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Design state moves only in the update region, so these are the edge's sampled values
      do begin
         @(posedge clk);
         r = pready;
         q = prdata;
         e = pslverr;
         n++;
      end while (r !== 1'b1 && n < 40);
      t = (r !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a; // Released bus shows no stale value
      pwdata <= ~d;
      @(posedge clk);
   endtask
endmodule // asf_decoder_model

// ### test/test_add_subtract_flag_datapath.sv
// Self-checking bench for the add/subtract flag datapath
module test_add_subtract_flag_datapath;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [2:0] op;
      logic sf, im, rg;
      logic [31:0] a, b;
      logic [3:0] fi;
      logic [31:0] res;
      logic [3:0] fo;
   } asf_row_s;
   logic clk;
   logic reset_n;
   logic psel, penable, pwrite, pready, pslverr, re, t;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rq;
   int fails = 0;
   int check_count = 0;
   asf_row_s r;
   // Rows: op, set flags, immediate, rd 3 given, a, b, flags in, result, flags out
   asf_row_s rows [12] = '{
      '{3'h0, 1'h0, 1'h0, 1'h0, 32'h7fffffff, 32'h1, 4'h5, 32'h80000000, 4'h5},
      '{3'h0, 1'h1, 1'h0, 1'h0, 32'h7fffffff, 32'h1, 4'h0, 32'h80000000, 4'h9},
      '{3'h0, 1'h1, 1'h1, 1'h0, 32'hffffffff, 32'h1, 4'h0, 32'h0, 4'h6},
      '{3'h1, 1'h0, 1'h0, 1'h0, 32'h1, 32'h2, 4'h2, 32'h4, 4'h0},
      '{3'h2, 1'h0, 1'h1, 1'h0, 32'h5, 32'h7, 4'ha, 32'hfffffffe, 4'ha},
      '{3'h2, 1'h1, 1'h0, 1'h1, 32'h5, 32'h7, 4'h0, 32'hfffffffe, 4'h8},
      '{3'h2, 1'h1, 1'h0, 1'h0, 32'h80000000, 32'h1, 4'h0, 32'h7fffffff, 4'h3},
      '{3'h3, 1'h0, 1'h0, 1'h0, 32'ha, 32'h3, 4'h2, 32'h6, 4'h2},
      '{3'h3, 1'h1, 1'h0, 1'h0, 32'h3, 32'h3, 4'h0, 32'h0, 4'h6},
      '{3'h4, 1'h0, 1'h0, 1'h0, 32'h1, 32'h5, 4'h0, 32'hffffffff, 4'h8},
      '{3'h4, 1'h0, 1'h0, 1'h0, 32'h0, 32'h5, 4'h0, 32'h0, 4'h6},
      '{3'h4, 1'h0, 1'h0, 1'h0, 32'h80000000, 32'h5, 4'h0, 32'h80000000, 4'h9}
   };
   asf_datapath asf_datapath_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   asf_decoder_model asf_decoder_model_i (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // Core clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Compare seen against expected
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One bus transfer; a hang ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      asf_decoder_model_i.xfer(w, a, d, rq, re, t);
      if (t) begin
         fails++;
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rq, e, $sformatf("reg %h", a));
   endtask
   // Main sequence
   initial begin
      reset_n = 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      foreach (rows[i]) begin
         r = rows[i];
         wr(asf_pkg::ADDR_RF_SEL, 32'h1);
         wr(asf_pkg::ADDR_RF_DATA, r.a);
         wr(asf_pkg::ADDR_RF_SEL, 32'h2);
         wr(asf_pkg::ADDR_RF_DATA, r.im ? ~r.b : r.b);
         wr(asf_pkg::ADDR_IMM, r.im ? r.b : ~r.b);
         wr(asf_pkg::ADDR_FLAGS, {28'h0, r.fi});
         wr(asf_pkg::ADDR_CTRL, {12'h000, 4'h2, 4'h1, r.rg ? 4'h3 : 4'h0,
            2'h0, r.rg, r.im, r.sf, r.op});
         rchk(asf_pkg::ADDR_RESULT, r.res);
         rchk(asf_pkg::ADDR_FLAGS, {28'h0, r.fo});
         wr(asf_pkg::ADDR_RF_SEL, r.rg ? 32'h3 : 32'h1);
         rchk(asf_pkg::ADDR_RF_DATA, r.res);
      end
      // Unmapped read is refused and reads zero
      bus(1'b0, 8'h40, 32'h0);
      chk({31'h0, re}, 32'h1, "unmapped error");
      chk(rq, 32'h0, "unmapped data");
      // Result register ignores writes
      wr(asf_pkg::ADDR_RESULT, 32'h1234);
      rchk(asf_pkg::ADDR_RESULT, 32'h80000000);
      // Back-to-back sums, the second reads the first one's result
      wr(asf_pkg::ADDR_RF_SEL, 32'h1);
      wr(asf_pkg::ADDR_RF_DATA, 32'h1);
      wr(asf_pkg::ADDR_RF_SEL, 32'h2);
      wr(asf_pkg::ADDR_RF_DATA, 32'h1);
      wr(asf_pkg::ADDR_CTRL, 32'h00021000);
      wr(asf_pkg::ADDR_CTRL, 32'h00021000);
      rchk(asf_pkg::ADDR_RESULT, 32'h3);
      rchk(asf_pkg::ADDR_FLAGS, 32'h9);
      // Undefined operation code writes nothing and keeps the flags
      wr(asf_pkg::ADDR_CTRL, 32'h0002100d);
      rchk(asf_pkg::ADDR_RESULT, 32'h3);
      rchk(asf_pkg::ADDR_FLAGS, 32'h9);
      wr(asf_pkg::ADDR_RF_SEL, 32'h1);
      rchk(asf_pkg::ADDR_RF_DATA, 32'h3);
      // Stack pointer slot steps by a word-multiple constant, up then down
      wr(asf_pkg::ADDR_RF_SEL, 32'hd);
      wr(asf_pkg::ADDR_RF_DATA, 32'h100);
      wr(asf_pkg::ADDR_IMM, 32'h1fc);
      wr(asf_pkg::ADDR_CTRL, 32'h0000dd30);
      rchk(asf_pkg::ADDR_RESULT, 32'h2fc);
      wr(asf_pkg::ADDR_CTRL, 32'h0000dd32);
      rchk(asf_pkg::ADDR_RESULT, 32'h100);
      rchk(asf_pkg::ADDR_RF_DATA, 32'h100);
      // Program counter slot plus a word-multiple constant into a low register
      wr(asf_pkg::ADDR_RF_SEL, 32'hf);
      wr(asf_pkg::ADDR_RF_DATA, 32'h1000);
      wr(asf_pkg::ADDR_IMM, 32'h3fc);
      wr(asf_pkg::ADDR_CTRL, 32'h0000f330);
      wr(asf_pkg::ADDR_RF_SEL, 32'h3);
      rchk(asf_pkg::ADDR_RF_DATA, 32'h13fc);
      rchk(asf_pkg::ADDR_FLAGS, 32'h9);
      // Reset in mid-run clears all state
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      rchk(asf_pkg::ADDR_FLAGS, 32'h0);
      rchk(asf_pkg::ADDR_RESULT, 32'h0);
      rchk(asf_pkg::ADDR_STATUS, 32'h0);
      rchk(asf_pkg::ADDR_RF_DATA, 32'h0);
      test_done();
   end
endmodule // test_add_subtract_flag_datapath
